// File: rtl/can_mode_defines.svh
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH

// register addresses
`define CM_ADDR_CTRL        8'h00
`define CM_ADDR_STAT        8'h01
`define CM_ADDR_WIC         8'h02

// control register fields
`define CM_CTRL_MODE_LSB    0
`define CM_CTRL_SLEEP_BIT   2
`define CM_CTRL_CPE_BIT     3
`define CM_CTRL_TEST_MODE_SELECT_LSB    4

// status register fields
`define CM_STAT_MODE_LSB    0
`define CM_STAT_TEST_BIT    2
`define CM_STAT_CLKEN_BIT   3

// wakeup interrupt control fields
`define CM_WIC_EN_BIT       0
`define CM_WIC_FLAG_BIT     1

// mode codes
`define CM_MODE_OPER        2'h0
`define CM_MODE_RESET       2'h1
`define CM_MODE_HALT        2'h2
`define CM_MODE_SLEEP       2'h3

// test mode select codes
`define CM_TEST_MODE_SELECT_NORMAL      2'h0
`define CM_TEST_MODE_SELECT_LISTEN      2'h1
`define CM_TEST_MODE_SELECT_EXT_LOOP    2'h2
`define CM_TEST_MODE_SELECT_INT_LOOP    2'h3

// reset values
`define CM_RST_CPE          1'b0
`define CM_RST_WAKE_EN      1'b0
`define CM_RST_RDATA        8'h00
`define CM_RST_RECESSIVE    1'b1

`endif

// File: rtl/can_mode_pkg.sv
package can_mode_pkg;

  typedef enum logic [1:0] {
    mode_oper,
    mode_reset,
    mode_halt,
    mode_sleep
  } mode_type;

  typedef enum logic [1:0] {
    tm_normal,
    tm_listen,
    tm_ext_loop,
    tm_int_loop
  } test_mode_type;

  typedef struct packed {
    mode_type      mode;
    mode_type      ret_mode;
    test_mode_type tmode;
    logic          controller_enable_bit;
    logic          wake_en;
    logic          wake_flag;
    logic [7:0]    rdata;
    logic          tx_pin;
    logic          rx_out;
    logic          ack_self;
    logic          tx_grant;
    logic          store_en;
    logic          clk_en;
    logic          irq;
  } ctrl_state_type;

  typedef struct packed {
    logic rx_prev;
    logic fall;
  } wake_state_type;

endpackage

// File: rtl/can_wake_detect.sv
`timescale 1ns/10ps
`include "can_mode_defines.svh"

module can_wake_detect (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rx_i,
  output logic      fall_o
);
  import can_mode_pkg::*;

  wake_state_type state_r;
  wake_state_type state_nxt;

  // a recessive idle is assumed at reset so a bus held low fires a fall at once
  always_comb begin
    state_nxt         = state_r;
    state_nxt.rx_prev = rx_i;
    state_nxt.fall    = state_r.rx_prev & ~rx_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r.rx_prev <= `CM_RST_RECESSIVE;
      state_r.fall    <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign fall_o = state_r.fall;

endmodule

// File: rtl/can_mode_ctrl.sv
`timescale 1ns/10ps
`include "can_mode_defines.svh"

module can_mode_ctrl (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       proto_tx_i,
  input  wire logic       proto_tx_start_req_i,
  output logic            proto_rx_o,
  output logic            tx_start_grant_o,
  output logic            ack_self_o,
  output logic            rx_store_en_o,
  output logic            proto_clk_en_o,
  input  wire logic       bus_receive_pin_i,
  output logic            bus_transmit_pin_o,
  output logic            wakeup_irq_o
);
  import can_mode_pkg::*;

  ctrl_state_type state_r;
  ctrl_state_type state_nxt;
  logic           wake_fall;
  logic           ctrl_wr;
  logic           wic_wr;
  logic           wake_event;
  logic           active;

  function automatic test_mode_type decode_test_mode_select(input logic [1:0] code);
    test_mode_type tm;
    tm = tm_normal;
    unique case (code)
      `CM_TEST_MODE_SELECT_NORMAL:   tm = tm_normal;
      `CM_TEST_MODE_SELECT_LISTEN:   tm = tm_listen;
      `CM_TEST_MODE_SELECT_EXT_LOOP: tm = tm_ext_loop;
      `CM_TEST_MODE_SELECT_INT_LOOP: tm = tm_int_loop;
    endcase
    return tm;
  endfunction

  function automatic logic [1:0] code_test_mode_select(input test_mode_type tm);
    logic [1:0] code;
    code = `CM_TEST_MODE_SELECT_NORMAL;
    unique case (tm)
      tm_normal:   code = `CM_TEST_MODE_SELECT_NORMAL;
      tm_listen:   code = `CM_TEST_MODE_SELECT_LISTEN;
      tm_ext_loop: code = `CM_TEST_MODE_SELECT_EXT_LOOP;
      tm_int_loop: code = `CM_TEST_MODE_SELECT_INT_LOOP;
    endcase
    return code;
  endfunction

  function automatic logic [1:0] code_mode(input mode_type m);
    logic [1:0] code;
    code = `CM_MODE_OPER;
    unique case (m)
      mode_oper:  code = `CM_MODE_OPER;
      mode_reset: code = `CM_MODE_RESET;
      mode_halt:  code = `CM_MODE_HALT;
      mode_sleep: code = `CM_MODE_SLEEP;
    endcase
    return code;
  endfunction

  can_wake_detect i_can_wake_detect (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .rx_i       (bus_receive_pin_i),
    .fall_o     (wake_fall)
  );

  assign ctrl_wr    = reg_wr_i && (reg_addr_i == `CM_ADDR_CTRL);
  assign wic_wr     = reg_wr_i && (reg_addr_i == `CM_ADDR_WIC);
  assign wake_event = wake_fall && (state_r.mode == mode_sleep) && state_r.wake_en
                      && state_r.controller_enable_bit;
  assign active     = (state_r.mode != mode_sleep) && state_r.controller_enable_bit;

  always_comb begin
    state_nxt = state_r;

    // mode requests
    if (ctrl_wr) begin
      if (state_r.mode == mode_sleep) begin
        if (!reg_wdata_i[`CM_CTRL_SLEEP_BIT]) begin
          state_nxt.mode = state_r.ret_mode;
        end
      end else if (reg_wdata_i[`CM_CTRL_SLEEP_BIT]) begin
        // sleep straight from operation is refused, mode stays as it is
        if (state_r.mode == mode_reset || state_r.mode == mode_halt) begin
          state_nxt.ret_mode = state_r.mode;
          state_nxt.mode     = mode_sleep;
        end
      end else begin
        unique case (reg_wdata_i[`CM_CTRL_MODE_LSB +: 2])
          `CM_MODE_OPER:  state_nxt.mode = mode_oper;
          `CM_MODE_RESET: state_nxt.mode = mode_reset;
          `CM_MODE_HALT:  state_nxt.mode = mode_halt;
          `CM_MODE_SLEEP: state_nxt.mode = state_r.mode;
        endcase
      end
      state_nxt.controller_enable_bit = reg_wdata_i[`CM_CTRL_CPE_BIT];
      // test mode changes only take effect from halt; protects a frame in flight
      if (state_r.mode == mode_halt) begin
        state_nxt.tmode = decode_test_mode_select(reg_wdata_i[`CM_CTRL_TEST_MODE_SELECT_LSB +: 2]);
      end
    end

    // wakeup enable and sticky flag; a new wake event beats the clear
    if (wic_wr) begin
      state_nxt.wake_en = reg_wdata_i[`CM_WIC_EN_BIT];
      if (reg_wdata_i[`CM_WIC_FLAG_BIT]) begin
        state_nxt.wake_flag = 1'b0;
      end
    end
    if (wake_event) begin
      state_nxt.wake_flag = 1'b1;
    end
    state_nxt.irq = state_nxt.wake_flag;

    // read data stands for one cycle only
    state_nxt.rdata = `CM_RST_RDATA;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `CM_ADDR_CTRL: begin
          state_nxt.rdata[`CM_CTRL_MODE_LSB +: 2] =
            code_mode((state_r.mode == mode_sleep) ? state_r.ret_mode : state_r.mode);
          state_nxt.rdata[`CM_CTRL_SLEEP_BIT]     = (state_r.mode == mode_sleep);
          state_nxt.rdata[`CM_CTRL_CPE_BIT]       = state_r.controller_enable_bit;
          state_nxt.rdata[`CM_CTRL_TEST_MODE_SELECT_LSB +: 2] = code_test_mode_select(state_r.tmode);
        end
        `CM_ADDR_STAT: begin
          state_nxt.rdata[`CM_STAT_MODE_LSB +: 2] = code_mode(state_r.mode);
          state_nxt.rdata[`CM_STAT_TEST_BIT]      = (state_r.tmode != tm_normal);
          state_nxt.rdata[`CM_STAT_CLKEN_BIT]     = state_r.clk_en;
        end
        `CM_ADDR_WIC: begin
          state_nxt.rdata[`CM_WIC_EN_BIT]   = state_r.wake_en;
          state_nxt.rdata[`CM_WIC_FLAG_BIT] = state_r.wake_flag;
        end
        default: state_nxt.rdata = `CM_RST_RDATA;
      endcase
    end

    // bus side routing; one register stage on every path
    state_nxt.clk_en   = (state_r.mode != mode_sleep);
    state_nxt.tx_pin   = `CM_RST_RECESSIVE;
    state_nxt.rx_out   = `CM_RST_RECESSIVE;
    state_nxt.ack_self = 1'b0;
    state_nxt.store_en = active && (state_r.mode == mode_oper);
    state_nxt.tx_grant = 1'b0;
    if (active) begin
      unique case (state_r.tmode)
        tm_normal: begin
          state_nxt.tx_pin   = proto_tx_i;
          state_nxt.rx_out   = bus_receive_pin_i;
          state_nxt.tx_grant = proto_tx_start_req_i && (state_r.mode == mode_oper);
        end
        tm_listen: begin
          // dominant wishes of the core come back inside; the bus never sees them
          state_nxt.rx_out = bus_receive_pin_i & proto_tx_i;
        end
        tm_ext_loop: begin
          state_nxt.tx_pin   = proto_tx_i;
          state_nxt.rx_out   = bus_receive_pin_i;
          state_nxt.ack_self = 1'b1;
          state_nxt.tx_grant = proto_tx_start_req_i && (state_r.mode == mode_oper);
        end
        tm_int_loop: begin
          state_nxt.rx_out   = proto_tx_i;
          state_nxt.ack_self = 1'b1;
          state_nxt.tx_grant = proto_tx_start_req_i && (state_r.mode == mode_oper);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r.mode      <= mode_reset;
      state_r.ret_mode  <= mode_reset;
      state_r.tmode     <= tm_normal;
      state_r.controller_enable_bit       <= `CM_RST_CPE;
      state_r.wake_en   <= `CM_RST_WAKE_EN;
      state_r.wake_flag <= 1'b0;
      state_r.rdata     <= `CM_RST_RDATA;
      state_r.tx_pin    <= `CM_RST_RECESSIVE;
      state_r.rx_out    <= `CM_RST_RECESSIVE;
      state_r.ack_self  <= 1'b0;
      state_r.tx_grant  <= 1'b0;
      state_r.store_en  <= 1'b0;
      state_r.clk_en    <= 1'b1;
      state_r.irq       <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_o        = state_r.rdata;
  assign proto_rx_o         = state_r.rx_out;
  assign tx_start_grant_o   = state_r.tx_grant;
  assign ack_self_o         = state_r.ack_self;
  assign rx_store_en_o      = state_r.store_en;
  assign proto_clk_en_o     = state_r.clk_en;
  assign bus_transmit_pin_o = state_r.tx_pin;
  assign wakeup_irq_o       = state_r.irq;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_sleep_req;
    ctrl_wr && reg_wdata_i[`CM_CTRL_SLEEP_BIT] && (state_r.mode != mode_sleep);
  endsequence

  sequence s_sleep_cancel;
    ctrl_wr && !reg_wdata_i[`CM_CTRL_SLEEP_BIT] && (state_r.mode == mode_sleep);
  endsequence

  sequence s_test_mode_select_wr(logic [1:0] code);
    ctrl_wr && (state_r.mode == mode_halt)
      && (reg_wdata_i[`CM_CTRL_TEST_MODE_SELECT_LSB +: 2] == code);
  endsequence

  property p_sleep_quiet;
    (state_r.mode == mode_sleep) ##1 (state_r.mode == mode_sleep)
      |-> !proto_clk_en_o && bus_transmit_pin_o && !tx_start_grant_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

  property p_sleep_entry;
    s_sleep_req |=> (state_r.mode == mode_sleep) == ($past(state_r.mode) != mode_oper);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");

  property p_wake_irq;
    wake_event |=> wakeup_irq_o ##1 (wakeup_irq_o || $past(wic_wr));
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wakeup irq missing");

  property p_sleep_return;
    s_sleep_cancel |=> (state_r.mode == $past(state_r.ret_mode)) && (state_r.mode != mode_oper);
  endproperty
  a_sleep_return: assert property (p_sleep_return) else $error("wrong return mode");

  property p_listen_store;
    (state_r.tmode == tm_listen && state_r.mode == mode_oper && state_r.controller_enable_bit)
      |=> rx_store_en_o;
  endproperty
  a_listen_store: assert property (p_listen_store) else $error("listen store off");

  property p_listen_tx;
    (state_r.tmode == tm_listen) |=> bus_transmit_pin_o && !tx_start_grant_o;
  endproperty
  a_listen_tx: assert property (p_listen_tx) else $error("listen drives bus");

  property p_listen_loop;
    (state_r.tmode == tm_listen) && active && !proto_tx_i |=> !proto_rx_o;
  endproperty
  a_listen_loop: assert property (p_listen_loop) else $error("dominant not looped");

  property p_test_mode_select_listen;
    s_test_mode_select_wr(`CM_TEST_MODE_SELECT_LISTEN) |=> (state_r.tmode == tm_listen);
  endproperty
  a_test_mode_select_listen: assert property (p_test_mode_select_listen) else $error("01b not listen");

  property p_ext_ack;
    (state_r.tmode == tm_ext_loop) && active |=> ack_self_o && (proto_rx_o == $past(bus_receive_pin_i));
  endproperty
  a_ext_ack: assert property (p_ext_ack) else $error("ext loop ack");

  property p_test_mode_select_ext;
    s_test_mode_select_wr(`CM_TEST_MODE_SELECT_EXT_LOOP) |=> (state_r.tmode == tm_ext_loop);
  endproperty
  a_test_mode_select_ext: assert property (p_test_mode_select_ext) else $error("10b not ext loop");

  property p_test_mode_select_int;
    s_test_mode_select_wr(`CM_TEST_MODE_SELECT_INT_LOOP) |=> (state_r.tmode == tm_int_loop);
  endproperty
  a_test_mode_select_int: assert property (p_test_mode_select_int) else $error("11b not int loop");

  property p_int_loop;
    (state_r.tmode == tm_int_loop) && active |=> (proto_rx_o == $past(proto_tx_i));
  endproperty
  a_int_loop: assert property (p_int_loop) else $error("int loop path");

  property p_int_tx;
    (state_r.tmode == tm_int_loop) && active |=> bus_transmit_pin_o && ack_self_o;
  endproperty
  a_int_tx: assert property (p_int_tx) else $error("int loop tx pin");

  property p_normal;
    s_test_mode_select_wr(`CM_TEST_MODE_SELECT_NORMAL) ##1 active
      |=> !ack_self_o && (bus_transmit_pin_o == $past(proto_tx_i));
  endproperty
  a_normal: assert property (p_normal) else $error("00b not normal");

  sequence s_wake_armed;
    (state_r.mode == mode_sleep) && state_r.wake_en && state_r.controller_enable_bit;
  endsequence

  // the fall is seen one edge late, so the sleep must last across that edge
  property p_wake_path;
    s_wake_armed ##0 $fell(bus_receive_pin_i) ##1 s_wake_armed |=> wakeup_irq_o;
  endproperty
  a_wake_path: assert property (p_wake_path) else $error("wake path broken");

  property p_wake_off;
    !state_r.wake_en && !state_r.wake_flag |=> !wakeup_irq_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("irq while disabled");

  property p_sleep_idle;
    (state_r.mode == mode_sleep) |=> !rx_store_en_o && proto_rx_o && !ack_self_o;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("core busy in sleep");

  property p_listen_rx;
    (state_r.tmode == tm_listen) && active
      |=> proto_rx_o == ($past(bus_receive_pin_i) && $past(proto_tx_i));
  endproperty
  a_listen_rx: assert property (p_listen_rx) else $error("listen receive path");

  property p_ext_tx;
    (state_r.tmode == tm_ext_loop) && active |=> bus_transmit_pin_o == $past(proto_tx_i);
  endproperty
  a_ext_tx: assert property (p_ext_tx) else $error("ext loop tx pin");

endmodule

// File: tb/can_bus_model.sv
`timescale 1ns/10ps

module can_bus_model (
  input  wire logic tx_pin_i,
  input  wire logic node_dom_i,
  output logic      rx_pin_o
);
  // wired-and bus seen through the transceiver: dominant 0 wins.
  // a released bus rests recessive through its termination, never at the last value.
  assign rx_pin_o = tx_pin_i & ~node_dom_i;
endmodule

// File: tb/can_mode_ctrl_test.sv
`timescale 1ns/10ps
`include "can_mode_defines.svh"

module can_mode_ctrl_test;
  logic       core_clk_i = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic [7:0] addr       = 8'h00;
  logic [7:0] wdata      = 8'h00;
  logic [7:0] rdv;
  logic [7:0] tm;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       ptx        = 1'b1;
  logic       preq       = 1'b0;
  logic       node       = 1'b0;
  logic       exp_pin;
  logic       exp_rx;
  logic       bus;
  logic [7:0] rdata;
  logic       prx, grant, ack, store, clk_en, tx_pin, rx_pin, irq;
  int         errors     = 0;
  int         compares   = 0;
  int         cycles     = 0;

  can_mode_ctrl i_can_mode_ctrl (
    .core_clk_i           (core_clk_i),
    .sys_rst_i            (sys_rst_i),
    .reg_addr_i           (addr),
    .reg_wdata_i          (wdata),
    .reg_wr_i             (wr),
    .reg_rd_i             (rd),
    .reg_rdata_o          (rdata),
    .proto_tx_i           (ptx),
    .proto_tx_start_req_i (preq),
    .proto_rx_o           (prx),
    .tx_start_grant_o     (grant),
    .ack_self_o           (ack),
    .rx_store_en_o        (store),
    .proto_clk_en_o       (clk_en),
    .bus_receive_pin_i    (rx_pin),
    .bus_transmit_pin_o   (tx_pin),
    .wakeup_irq_o         (irq)
  );

  can_bus_model i_can_bus_model (
    .tx_pin_i   (tx_pin),
    .node_dom_i (node),
    .rx_pin_o   (rx_pin)
  );

  always #25 core_clk_i = ~core_clk_i;

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("counts: errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr    <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // pin to pin path is two registers deep, so three edges settle it
  task automatic drive(input logic tx, input logic nd, input logic rq);
    @(posedge core_clk_i);
    ptx  <= tx;
    node <= nd;
    preq <= rq;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("pin", 8'(tx_pin), 8'h01);
    chk("prx", 8'(prx), 8'h01);
    chk("irq", 8'(irq), 8'h00);
    chk("ack", 8'(ack), 8'h00);
    chk("grant", 8'(grant), 8'h00);
    chk("clk_en", 8'(clk_en), 8'h01);
    chk("store", 8'(store), 8'h00);
    rd_reg(`CM_ADDR_CTRL, rdv);
    chk("ctrl", rdv, 8'h01);
    rd_reg(`CM_ADDR_STAT, rdv);
    chk("stat", rdv, 8'h09);
    rd_reg(`CM_ADDR_WIC, rdv);
    chk("wic", rdv, 8'h00);
    rd_reg(8'h07, rdv);
    chk("unmapped", rdv, 8'h00);
    $display("test reset done");

    wr_reg(`CM_ADDR_CTRL, 8'h0A);
    for (int c = 0; c < 4; c++) begin
      tm = 8'(c << 4);
      wr_reg(`CM_ADDR_CTRL, 8'h0A | tm);
      wr_reg(`CM_ADDR_CTRL, 8'h08 | tm);
      rd_reg(`CM_ADDR_STAT, rdv);
      chk("stat", rdv, (c != 0) ? 8'h0C : 8'h08);
      rd_reg(`CM_ADDR_CTRL, rdv);
      chk("ctrl", rdv, 8'h08 | tm);
      for (int v = 0; v < 4; v++) begin
        drive(v[0], v[1], c != 1);
        exp_pin = (c == 1 || c == 3) ? 1'b1 : v[0];
        bus     = exp_pin & ~v[1];
        exp_rx  = (c == 3) ? v[0] : (c == 1) ? (bus & v[0]) : bus;
        chk("pin", 8'(tx_pin), 8'(exp_pin));
        chk("prx", 8'(prx), 8'(exp_rx));
        chk("ack", 8'(ack), 8'(c >= 2));
        chk("grant", 8'(grant), 8'(c != 1));
        chk("store", 8'(store), 8'h01);
      end
      wr_reg(`CM_ADDR_CTRL, 8'h0A | tm);
      $display("test mode %0d done", c);
    end

    wr_reg(`CM_ADDR_CTRL, 8'h0A);
    for (int m = 1; m < 3; m++) begin
      wr_reg(`CM_ADDR_CTRL, 8'h08 | 8'(m));
      wr_reg(`CM_ADDR_WIC, 8'(m - 1));
      wr_reg(`CM_ADDR_CTRL, 8'h0F);
      drive(1'b0, 1'b0, 1'b1);
      chk("clk_en", 8'(clk_en), 8'h00);
      chk("pin", 8'(tx_pin), 8'h01);
      chk("prx", 8'(prx), 8'h01);
      chk("grant", 8'(grant), 8'h00);
      chk("store", 8'(store), 8'h00);
      chk("ack", 8'(ack), 8'h00);
      rd_reg(`CM_ADDR_STAT, rdv);
      chk("stat", rdv, 8'h03);
      rd_reg(`CM_ADDR_CTRL, rdv);
      chk("ctrl", rdv, 8'h0C | 8'(m));
      drive(1'b0, 1'b1, 1'b1);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("irq", 8'(irq), 8'(m - 1));
      rd_reg(`CM_ADDR_WIC, rdv);
      chk("wic", rdv, (m == 2) ? 8'h03 : 8'h00);
      wr_reg(`CM_ADDR_WIC, 8'h02 | 8'(m - 1));
      drive(1'b1, 1'b0, 1'b0);
      chk("irq", 8'(irq), 8'h00);
      wr_reg(`CM_ADDR_CTRL, 8'h0B);
      drive(1'b1, 1'b0, 1'b0);
      chk("clk_en", 8'(clk_en), 8'h01);
      rd_reg(`CM_ADDR_STAT, rdv);
      chk("stat", rdv, 8'h08 | 8'(m));
      $display("test sleep from mode %0d done", m);
    end
    finish_test();
  end
endmodule
